// ### mies_top.sv
// Purpose: Executes one instruction word of the subset per APB write to the instruction register.
// Assumes: APB master obeys the standard protocol; one mclk per phase.
// Notes:   Every APB transfer, read or write, waits while an instruction runs.
//
// Contract
// - Word 0x0064 clears watchdog counter and prescaler in one cycle.
// - Watchdog clear sets expired and sleep flags, others unchanged.
// - Watchdog clear: decode Q1, no read Q2, clear in Q4.
// - Clear work: no read in Q2, write zero in Q4.
// - Rotate left through carry changes only carry.
// - Rotate right through carry changes only carry.
// - Byte ops read in Q2, compute in Q3, write in Q4.
// - Byte ops take a 7-bit file address and one destination bit.
// - Subtract computes file minus work by two's complement.
// - Subtract updates carry, half carry and zero.
// - Subtract carry is one without borrow, zero when negative.
// - Nibble exchange swaps upper and lower nibbles.
// - Nibble exchange runs one cycle and alters no flag.
// - Direction load copies work to direction register 5 to 7.
// - Direction load pattern is 00 0000 0110 0fff, one cycle.
// - Direction registers are also plain file registers.
// - Destination bit zero writes work, one writes the file.
// - An instruction cycle is four oscillator periods.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module mies_top import mies_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  dirOut [DIR_COUNT]
);

  mies_phase_t        phase_r;
  mies_op_t           op_r;
  logic [13:0]        opcode_r;
  logic [7:0]         work_r;
  mies_flags_t        flags_r;
  logic [7:0]         wdtPre_r;
  logic [7:0]         wdtCnt_r;
  logic [6:0]         faddr_r;
  logic [7:0]         operand_r;
  mies_alu_t          aluRes_r;
  logic               rdWait_r;
  logic [7:0]         dirReg_r [DIR_COUNT];
  logic               busy;
  logic               access;
  logic               wrCommit;
  logic [6:0]         fileAddr;
  logic               destFile;
  logic               isByte;
  logic               atQ4;
  logic               fileHitDir;
  logic               apbHitDir;
  logic [7:0]         operandNow;
  logic               memWe;
  logic [6:0]         memAddr;
  logic [7:0]         memWdata;
  logic [7:0]         memRdata;
  mies_alu_t          aluRes;
  logic [31:0]        readMux;
  logic               mapped;

  // ****************************************
  // Decode
  // ****************************************
  function automatic mies_op_t decodeOp(input logic [13:0] w);
    mies_op_t o;
    o = OP_NOP;
    if (w == OPC_DOGCLR) begin
      o = OP_DOGCLR;
    // direction load pattern, selector 5 to 7.
    end else if (w[13:3] == OPC_DIRLD_HI && w[2:0] >= DIR_SEL_MIN) begin
      o = OP_DIRLD;
    end else if (w[13:7] == OPC_WCLR_HI) begin
      o = OP_WCLR;
    end else begin
      case (w[13:8])
        OPC_ROTL: o = OP_ROTL;
        OPC_ROTR: o = OP_ROTR;
        OPC_SUB:  o = OP_SUB;
        OPC_SWAP: o = OP_SWAP;
        default:  o = OP_NOP;
      endcase
    end
    return o;
  endfunction

  function automatic logic isDir(input logic [6:0] a);
    return (a >= DIR_FIRST) && (a <= DIR_LAST);
  endfunction

  assign fileAddr   = opcode_r[6:0];
  assign destFile   = opcode_r[7];
  assign isByte     = (op_r == OP_ROTL) || (op_r == OP_ROTR) ||
                      (op_r == OP_SUB) || (op_r == OP_SWAP);
  assign busy       = (phase_r != PH_IDLE);
  assign atQ4       = (phase_r == PH_Q4);
  assign access     = psel && penable;
  assign wrCommit   = access && pready && pwrite;
  assign fileHitDir = isDir(fileAddr);
  assign apbHitDir  = isDir(faddr_r);

  // ****************************************
  // Quarter phase sequencer
  // ****************************************
  // four periods per instruction cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      phase_r <= PH_IDLE;
    end else begin
      unique case (phase_r)
        PH_IDLE: if (wrCommit && paddr == ADDR_INSTR) phase_r <= PH_Q1;
        PH_Q1:   phase_r <= PH_Q2;
        PH_Q2:   phase_r <= PH_Q3;
        PH_Q3:   phase_r <= PH_Q4;
        PH_Q4:   phase_r <= PH_IDLE;
        default: phase_r <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      opcode_r <= 14'h0000;
      op_r     <= OP_NOP;
    end else if (phase_r == PH_IDLE && wrCommit && paddr == ADDR_INSTR) begin
      opcode_r <= pwdata[13:0];
    end else if (phase_r == PH_Q1) begin
      op_r <= decodeOp(opcode_r);
    end
  end

  // ****************************************
  // File register access and compute
  // ****************************************
  // address held from Q1, data arrives in Q2.
  assign memAddr    = busy ? fileAddr : faddr_r;
  assign memWdata   = busy ? aluRes_r.value : pwdata[7:0];
  assign memWe      = busy ? (atQ4 && isByte && destFile && !fileHitDir)
                           : (wrCommit && paddr == ADDR_FDATA && !apbHitDir);
  // direction registers answer at their file addresses.
  assign operandNow = fileHitDir ? dirReg_r[2'(fileAddr - DIR_FIRST)] : memRdata;

  mies_fmem mies_fmem_inst (
    .mclk  (mclk),
    .we    (memWe),
    .addr  (memAddr),
    .wdata (memWdata),
    .rdata (memRdata)
  );

  mies_alu mies_alu_inst (
    .op      (op_r),
    .operand (operandNow),
    .work    (work_r),
    .carryIn (flags_r.carry),
    .res     (aluRes)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      operand_r <= 8'h00;
      aluRes_r  <= '0;
    end else if (phase_r == PH_Q3) begin
      operand_r <= operandNow;
      aluRes_r  <= aluRes;
    end
  end

  // ****************************************
  // Working register and flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      work_r <= WORK_RESET;
    end else if (!busy && wrCommit && paddr == ADDR_WORK) begin
      work_r <= pwdata[7:0];
    end else if (atQ4 && op_r == OP_WCLR) begin
      work_r <= 8'h00;
    end else if (atQ4 && isByte && !destFile) begin
      work_r <= aluRes_r.value;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_r <= mies_flags_t'(FLAGS_RESET);
    end else if (!busy && wrCommit && paddr == ADDR_STATUS) begin
      flags_r <= (flags_r & ~FLAGS_SWMASK) | (pwdata[4:0] & FLAGS_SWMASK);
    end else if (atQ4) begin
      case (op_r)
        // set expired and sleep flags only.
        OP_DOGCLR: begin
          flags_r.wdtExpired <= 1'b1;
          flags_r.sleep      <= 1'b1;
        end
        OP_WCLR: flags_r.zero <= 1'b1;
        OP_ROTL, OP_ROTR: flags_r.carry <= aluRes_r.carry;
        OP_SUB: begin
          flags_r.carry     <= aluRes_r.carry;
          flags_r.halfCarry <= aluRes_r.halfCarry;
          flags_r.zero      <= aluRes_r.zero;
        end
        default: flags_r <= flags_r;
      endcase
    end
  end

  // ****************************************
  // Watchdog counter and prescaler
  // ****************************************
  // both cleared together.
  always_ff @(posedge mclk) begin
    if (reset || (atQ4 && op_r == OP_DOGCLR)) begin
      // clear lands in the final phase.
      wdtPre_r <= 8'h00;
      wdtCnt_r <= 8'h00;
    end else begin
      wdtPre_r <= wdtPre_r + 8'h01;
      if (wdtPre_r == 8'hff) begin
        wdtCnt_r <= wdtCnt_r + 8'h01;
      end
    end
  end

  // ****************************************
  // Direction registers
  // ****************************************
  for (genvar i = 0; i < DIR_COUNT; i++) begin : g_dir
    always_ff @(posedge mclk) begin
      if (reset) begin
        dirReg_r[i] <= DIR_RESET;
      end else if (!busy && wrCommit && paddr == ADDR_FDATA && apbHitDir &&
                   2'(faddr_r - DIR_FIRST) == 2'(i)) begin
        // direct write as a file register.
        dirReg_r[i] <= pwdata[7:0];
      end else if (atQ4 && op_r == OP_DIRLD &&
                   2'(opcode_r[2:0] - DIR_SEL_MIN) == 2'(i)) begin
        // copy work to the selected register.
        dirReg_r[i] <= work_r;
      end else if (atQ4 && isByte && destFile && fileHitDir &&
                   2'(fileAddr - DIR_FIRST) == 2'(i)) begin
        dirReg_r[i] <= aluRes_r.value;
      end
    end
    assign dirOut[i] = dirReg_r[i];
  end

  // ****************************************
  // APB slave
  // ****************************************
  always_comb begin
    readMux = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr)
      ADDR_INSTR:  readMux = {18'h00000, opcode_r};
      ADDR_WORK:   readMux = {24'h000000, work_r};
      ADDR_STATUS: readMux = {26'h0000000, busy, flags_r};
      ADDR_WDOG:   readMux = {16'h0000, wdtCnt_r, wdtPre_r};
      ADDR_FADDR:  readMux = {25'h0000000, faddr_r};
      ADDR_FDATA:  readMux = {24'h000000,
                              apbHitDir ? dirReg_r[2'(faddr_r - DIR_FIRST)] : memRdata};
      ADDR_DIR:    readMux = {8'h00, dirReg_r[2], dirReg_r[1], dirReg_r[0]};
      default:     mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      faddr_r <= 7'h00;
    end else if (wrCommit && paddr == ADDR_FADDR) begin
      faddr_r <= pwdata[6:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      rdWait_r <= 1'b0;
    end else if (pready) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      rdWait_r <= 1'b0;
    end else if (access && !busy) begin
      if (!pwrite && paddr == ADDR_FDATA && !rdWait_r) begin
        rdWait_r <= 1'b1;
      end else begin
        pready  <= 1'b1;
        pslverr <= !mapped;
        prdata  <= pwrite ? 32'h0000_0000 : readMux;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence quarterRun_s;
    phase_r == PH_Q1 ##1 phase_r == PH_Q2 ##1 phase_r == PH_Q3 ##1 phase_r == PH_Q4;
  endsequence

  phase_walk_a: assert property (phase_r == PH_Q1 |-> quarterRun_s ##1 phase_r == PH_IDLE)
    else $error("instruction cycle is not four phases");
  wdt_clear_a: assert property (atQ4 && op_r == OP_DOGCLR |=> wdtCnt_r == 8'h00 && wdtPre_r == 8'h00)
    else $error("watchdog not cleared");
  wdt_flags_a: assert property (atQ4 && op_r == OP_DOGCLR |=>
      flags_r.wdtExpired && flags_r.sleep && flags_r.carry == $past(flags_r.carry))
    else $error("watchdog clear flags wrong");
  work_clear_a: assert property (atQ4 && op_r == OP_WCLR |=> work_r == 8'h00 && flags_r.zero)
    else $error("work not cleared");
  rotate_left_a: assert property (atQ4 && op_r == OP_ROTL |=>
      flags_r.carry == $past(operand_r[7]) && $stable(flags_r.zero))
    else $error("left rotate carry wrong");
  rotate_right_a: assert property (atQ4 && op_r == OP_ROTR |-> aluRes_r.value[7] == $past(flags_r.carry, 2))
    else $error("right rotate fill wrong");
  sub_borrow_a: assert property (atQ4 && op_r == OP_SUB |=>
      flags_r.carry == ($past(operand_r) >= $past(work_r)))
    else $error("subtract carry wrong");
  swap_nibble_a: assert property (atQ4 && op_r == OP_SWAP |->
      aluRes_r.value == {operand_r[3:0], operand_r[7:4]} ##1 $stable(flags_r))
    else $error("nibble exchange wrong");
  dest_work_a: assert property (atQ4 && isByte && !destFile |=> work_r == $past(aluRes_r.value))
    else $error("work destination not written");
  dir_load_a: assert property (atQ4 && op_r == OP_DIRLD |=>
      dirOut[2'($past(opcode_r[2:0]) - DIR_SEL_MIN)] == $past(work_r))
    else $error("direction load wrong");
  nop_quiet_a: assert property (atQ4 && op_r == OP_NOP |=> $stable(work_r) && $stable(flags_r))
    else $error("no-operation changed state");

endmodule

// ### mies_pkg.sv
// Purpose: Shared constants and types of the instruction execute subset.
// Assumes: One clock; one quarter phase of an instruction lasts one mclk period.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
package mies_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_WORK   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WDOG   = 8'h0c;
  localparam logic [7:0] ADDR_FADDR  = 8'h10;
  localparam logic [7:0] ADDR_FDATA  = 8'h14;
  localparam logic [7:0] ADDR_DIR    = 8'h18;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          FILE_AW      = 7;
  localparam int          FILE_DEPTH   = 128;
  localparam int          DIR_COUNT    = 3;
  localparam logic [6:0]  DIR_FIRST    = 7'h05;
  localparam logic [6:0]  DIR_LAST     = 7'h07;
  localparam logic [2:0]  DIR_SEL_MIN  = 3'h5;
  localparam logic [7:0]  DIR_RESET    = 8'hff;
  localparam logic [7:0]  WORK_RESET   = 8'h00;
  localparam int          STATUS_BUSY  = 5;
  localparam logic [4:0]  FLAGS_RESET  = 5'h18;
  localparam logic [4:0]  FLAGS_SWMASK = 5'h07;

  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [13:0] OPC_DOGCLR   = 14'h0064;
  localparam logic [10:0] OPC_DIRLD_HI = 11'h00c;
  localparam logic [6:0]  OPC_WCLR_HI  = 7'h02;
  localparam logic [5:0]  OPC_ROTL     = 6'h0d;
  localparam logic [5:0]  OPC_ROTR     = 6'h0c;
  localparam logic [5:0]  OPC_SUB     = 6'h02;
  localparam logic [5:0]  OPC_SWAP    = 6'h0e;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_Q1   = 5'b00010,
    PH_Q2   = 5'b00100,
    PH_Q3   = 5'b01000,
    PH_Q4   = 5'b10000
  } mies_phase_t;

  typedef enum logic [2:0] {
    OP_NOP, OP_WCLR, OP_DOGCLR, OP_ROTL, OP_ROTR, OP_SUB, OP_SWAP, OP_DIRLD
  } mies_op_t;

  typedef struct packed {
    logic wdtExpired;
    logic sleep;
    logic zero;
    logic halfCarry;
    logic carry;
  } mies_flags_t;

  typedef struct packed {
    logic [7:0] value;
    logic       carry;
    logic       halfCarry;
    logic       zero;
  } mies_alu_t;

endpackage

// ### mies_fmem.sv
// Purpose: File register memory, one write and one registered read port.
// Assumes: Read during write returns the old word.
// Notes:   Contents are not reset.
`timescale 1ns/1ps
module mies_fmem import mies_pkg::*; (
  input  wire logic               mclk,
  input  wire logic               we,
  input  wire logic [FILE_AW-1:0] addr,
  input  wire logic [7:0]         wdata,
  output logic      [7:0]         rdata
);

  logic [7:0] mem [FILE_DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ### mies_alu.sv
// Purpose: Data path of the byte-oriented operations.
// Assumes: Operand and working register are stable during the compute phase.
// Notes:   Purely combinational; the caller picks which flags to keep.
`timescale 1ns/1ps
module mies_alu import mies_pkg::*; (
  input  wire mies_op_t   op,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] work,
  input  wire logic       carryIn,
  output mies_alu_t       res
);

  logic [8:0] sum9;
  logic [4:0] low5;

  always_comb begin
    sum9 = {1'b0, operand} + {1'b0, ~work} + 9'h001;
    low5 = {1'b0, operand[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
    res  = '0;
    res.carry = carryIn;
    case (op)
      OP_ROTL: begin
        res.value = {operand[6:0], carryIn};
        res.carry = operand[7];
      end
      OP_ROTR: begin
        res.value = {carryIn, operand[7:1]};
        res.carry = operand[0];
      end
      OP_SUB: begin
        res.value     = sum9[7:0];
        res.carry     = sum9[8];
        res.halfCarry = low5[4];
      end
      OP_SWAP: res.value = {operand[3:0], operand[7:4]};
      default: res.value = 8'h00;
    endcase
    res.zero = (res.value == 8'h00);
  end

endmodule

// ### tb_top.sv
// Purpose: Self-checking bench of the instruction execute subset over APB.
// Assumes: Register map, opcode patterns and flag layout of mies_pkg.
// Notes:   Every instruction is started by a write of its word to the instruction register.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin \
  $display("wrong value %s expected %h seen %h", nm, ex, got); miscompares++; end end
module tb_top;
  import mies_pkg::*;
  logic        mclk    = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  dirOut [DIR_COUNT];
  int          miscompares = 0;
  int          checkCount  = 0;

  mies_top mies_top_inst (
    .mclk    (mclk),
    .reset   (reset),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .dirOut  (dirOut)
  );

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("wrong value pready expected 1 seen timeout");
      miscompares++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0, q, e);
    `CHK(nm, ex, q)
  endtask

  task automatic exec(input logic [13:0] op);
    wr(ADDR_INSTR, {18'h0, op});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    $display("watchdog ran out");
    miscompares++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0]  fv [4] = '{8'h03, 8'h02, 8'h01, 8'h10};
    logic [7:0]  wv [4] = '{8'h02, 8'h02, 8'h02, 8'h01};
    logic [31:0] q;
    logic [7:0]  res;
    logic [4:0]  fl;
    logic        e;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdChk(ADDR_STATUS, 32'h18, "statusReset");
    rdChk(ADDR_WORK, 32'h0, "workReset");
    rdChk(ADDR_DIR, 32'h00ffffff, "dirReset");
    $display("test reset done");

    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_FADDR, 32'h20);
    wr(ADDR_FDATA, 32'he6);
    exec(14'h0d20);
    rdChk(ADDR_WORK, 32'hcc, "rotLeftWork");
    rdChk(ADDR_STATUS, 32'h19, "rotLeftFlags");
    rdChk(ADDR_FDATA, 32'he6, "rotLeftFile");
    wr(ADDR_STATUS, 32'h06);
    exec(14'h0ca0);
    rdChk(ADDR_FDATA, 32'h73, "rotRightFile");
    rdChk(ADDR_STATUS, 32'h1e, "rotRightFlags");
    rdChk(ADDR_WORK, 32'hcc, "rotRightWork");
    $display("test rotate done");

    wr(ADDR_FADDR, 32'h7f);
    for (int i = 0; i < 4; i++) begin
      res = fv[i] - wv[i];
      fl = {2'b11, res == 8'h00, fv[i][3:0] >= wv[i][3:0], fv[i] >= wv[i]};
      wr(ADDR_STATUS, 32'h0);
      wr(ADDR_WORK, {24'h0, wv[i]});
      wr(ADDR_FDATA, {24'h0, fv[i]});
      exec({6'h02, i[0], 7'h7f});
      rdChk(ADDR_STATUS, {27'h0, fl}, "subFlags");
      rdChk(ADDR_WORK, {24'h0, i[0] ? wv[i] : res}, "subWork");
      rdChk(ADDR_FDATA, {24'h0, i[0] ? res : fv[i]}, "subFile");
    end
    $display("test subtract done");

    wr(ADDR_FDATA, 32'ha5);
    wr(ADDR_STATUS, 32'h05);
    exec(14'h0eff);
    rdChk(ADDR_FDATA, 32'h5a, "swapFile");
    exec(14'h0e7f);
    rdChk(ADDR_WORK, 32'ha5, "swapWork");
    rdChk(ADDR_STATUS, 32'h1d, "swapFlags");
    $display("test swap done");

    wr(ADDR_WORK, 32'h33);
    wr(ADDR_STATUS, 32'h03);
    exec(14'h017f);
    rdChk(ADDR_WORK, 32'h0, "clearWork");
    rdChk(ADDR_STATUS, 32'h1f, "clearWorkFlags");
    $display("test clear work done");

    wr(ADDR_STATUS, 32'h07);
    for (int f = 5; f < 8; f++) begin
      wr(ADDR_WORK, 32'h30 + f);
      exec(14'h0060 | f[13:0]);
      repeat (5) @(posedge mclk);
      `CHK("dirOut", 8'h30 + f[7:0], dirOut[f - 5])
    end
    rdChk(ADDR_DIR, 32'h00373635, "dirAll");
    rdChk(ADDR_STATUS, 32'h1f, "dirFlags");
    wr(ADDR_FADDR, 32'h05);
    rdChk(ADDR_FDATA, 32'h35, "dirAsFile");
    wr(ADDR_FADDR, 32'h06);
    wr(ADDR_FDATA, 32'h5c);
    `CHK("dirOutFile", 8'h5c, dirOut[1])
    $display("test direction done");

    foreach (fv[i]) begin
      exec(i == 0 ? 14'h0063 : (i == 1 ? 14'h3fff : (i == 2 ? 14'h0180 : 14'h0061)));
      rdChk(ADDR_WORK, 32'h37, "nopWork");
      rdChk(ADDR_STATUS, 32'h1f, "nopFlags");
      rdChk(ADDR_DIR, 32'h00375c35, "nopDir");
    end
    $display("test no-operation done");

    repeat (600) @(posedge mclk);
    apb(ADDR_WDOG, 1'b0, 32'h0, q, e);
    `CHK("wdogRunning", 1'b1, q[15:8] !== 8'h00)
    wr(ADDR_STATUS, 32'h05);
    exec(14'h0064);
    apb(ADDR_WDOG, 1'b0, 32'h0, q, e);
    `CHK("wdogCleared", 1'b1, q[15:0] < 16'h0010)
    rdChk(ADDR_STATUS, 32'h1d, "wdogFlags");
    $display("test watchdog clear done");

    apb(8'h1c, 1'b0, 32'h0, q, e);
    `CHK("errRead", 1'b1, e)
    apb(8'h20, 1'b1, 32'hff, q, e);
    `CHK("errWrite", 1'b1, e)
    rdChk(ADDR_WORK, 32'h37, "errNoEffect");
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
